// [verilog/acs_sequencer.sv]
// Successive-approximation conversion sequencer with control byte and result.
// Assumes the core writes bytes synchronously; comparator comes from analog.
//
// Overview of operation
// (RULE_01) Full conversion lasts nine and half periods
// (RULE_02) Bit period from osc/2, /8, /32, RC
// (RULE_03) Software keeps bit period above minimum
// (RULE_04) RC bit period about four microseconds
// (RULE_05) RC clock for sleep at high frequency
// (RULE_06) Analog-configured pins read as zero
// (RULE_07) Enable converter before setting start flag
// (RULE_08) Clearing go aborts, result untouched
// (RULE_09) Result holds latest conversion or write
// (RULE_10) After abort wait two periods, acquire
// (RULE_11) Completion clears go, sets done flag
// (RULE_12) Software waits acquisition before starting
// (RULE_13) Clock switching only among oscillator sources
// (RULE_14) Software times clock switch for resolution
// (RULE_15) Sleep conversions only with RC select
// (RULE_16) RC start delayed one instruction cycle
// (RULE_17) Sleep completion with irq enabled wakes
// (RULE_18) Sleep completion without irq powers down
// (RULE_19) Sleep with oscillator clock aborts, powers down
// (RULE_20) Sleep instruction follows the start write
// (RULE_21) Control byte field layout fixed
// (RULE_22) Two-period capacitor hold-off after completion
// (RULE_23) Converter off when on-bit clear
// (RULE_24) Result bits resolved MSB first
`timescale 1ns/10ps
module acs_sequencer
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    // Control byte access from the core
    input  wire logic       ctl_wr,
    input  wire logic [7:0] ctl_wdata,
    output logic      [7:0] ctl_rdata,
    // Result access from the core
    input  wire logic       result_wr,
    input  wire logic [7:0] result_wdata,
    output logic      [7:0] conversion_result,
    // Interrupt flag and enable, owned by the core's flag register
    input  wire logic       conv_done_irq_enable,
    input  wire logic       irq_flag_clear,
    output logic            conv_done_irq_flag,
    // Power mode
    input  wire logic       sleep_mode,
    output logic            wake_request,
    // Analog side
    input  wire logic       comparator_in,
    output logic      [7:0] dac_code,
    output logic            sample_switch,
    output logic            converter_powered,
    // Port read masking
    input  wire logic [4:0] port_pins,
    input  wire logic [4:0] analog_pin_mask,
    output logic      [4:0] port_read
);
    import acs_pkg::*;

    acs_state_type state;
    acs_state_type next_state;
    logic [7:0]    ctl;
    logic [7:0]    sar;
    logic [2:0]    bit_idx;
    logic [3:0]    span;
    logic [3:0]    rc_wait;
    logic          powered_down;
    logic          cmp_meta;
    logic          cmp_sync;
    logic [4:0]    pin_meta;
    logic [4:0]    pin_sync;
    logic          half_tick;
    logic          bit_tick;

    wire [1:0] clk_sel  = ctl[CTL_CLK_SEL_HI:CTL_CLK_SEL_LO]; // [RULE_21]
    wire       go_flag  = ctl[CTL_GO_BIT];
    wire       on_bit   = ctl[CTL_ON_BIT];
    wire       rc_sel   = (clk_sel == CLK_SEL_RC);
    wire       active   = on_bit && !powered_down; // [RULE_23]
    wire       go_clear = ctl_wr && !ctl_wdata[CTL_GO_BIT] && go_flag;
    wire       busy     = (state == ACS_DELAY) || (state == ACS_SAMPLE) || (state == ACS_CONVERT);
    // Sleep with an oscillator clock stops the divider, so abort at once
    wire       sleep_abort = sleep_mode && !rc_sel && busy;            // [RULE_19] [RULE_15]
    wire       abort       = (go_clear && busy) || sleep_abort;        // [RULE_08]
    wire       finish      = (state == ACS_CONVERT) && bit_tick && (bit_idx == 3'h0);
    // Abort restarts the divider so the hold-off is a whole two periods
    wire       div_run     = ((busy && (state != ACS_DELAY)) || (state == ACS_HOLDOFF)) && !abort;
    wire [7:0] trial       = sar | (8'h01 << bit_idx);                 // [RULE_24]
    // Clock select writes are accepted while busy only between oscillator codes
    wire       sel_ok      = !busy || (!rc_sel && (ctl_wdata[CTL_CLK_SEL_HI:CTL_CLK_SEL_LO] != CLK_SEL_RC)); // [RULE_13]
    wire [1:0] next_sel    = sel_ok ? ctl_wdata[CTL_CLK_SEL_HI:CTL_CLK_SEL_LO] : clk_sel;

    acs_bit_clock u_bit_clock
    (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .run       (div_run),
        .clk_sel   (clk_sel),
        .half_tick (half_tick),
        .bit_tick  (bit_tick)
    );

    // Comparator and pins are asynchronous to the reference clock
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
            pin_meta <= 5'h00;
            pin_sync <= 5'h00;
        end
        else
        begin
            cmp_meta <= comparator_in;
            cmp_sync <= cmp_meta;
            pin_meta <= port_pins;
            pin_sync <= pin_meta;
        end
    end

    // Port reads never show analog levels
    assign port_read = pin_sync & ~analog_pin_mask; // [RULE_06]

    // Next-state selection
    always_comb
    begin
        next_state = state;
        case (state)
            ACS_IDLE:
                if (active && go_flag)
                    next_state = rc_sel ? ACS_DELAY : ACS_SAMPLE;
            ACS_DELAY:
                if (rc_wait == 4'(INSTR_CYCLE_OSC - 1))
                    next_state = ACS_SAMPLE; // [RULE_16]
            ACS_SAMPLE:
                if (half_tick && span == 4'(SAMPLE_HALF_BITS - 1))
                    next_state = ACS_CONVERT; // [RULE_01]
            ACS_CONVERT:
                if (finish)
                    next_state = ACS_HOLDOFF;
            ACS_HOLDOFF:
                if (half_tick && span == 4'(2 * HOLD_OFF_BITS - 1))
                    next_state = ACS_IDLE; // [RULE_22] [RULE_10]
            default:
                next_state = ACS_IDLE;
        endcase
        if (abort)
            next_state = ACS_HOLDOFF;
        if (!on_bit)
            next_state = ACS_IDLE;
    end

    // Sequencer state and counters
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state   <= ACS_IDLE;
            span    <= 4'h0;
            rc_wait <= 4'h0;
            bit_idx <= 3'h7;
            sar     <= 8'h00;
        end
        else
        begin
            state   <= next_state;
            rc_wait <= (state == ACS_DELAY) ? rc_wait + 4'h1 : 4'h0;
            if (next_state != state)
                span <= 4'h0;
            else if ((state == ACS_SAMPLE || state == ACS_HOLDOFF) && half_tick)
                span <= span + 4'h1;
            if (state != ACS_CONVERT)
            begin
                bit_idx <= 3'h7;
                sar     <= 8'h00;
            end
            else if (bit_tick)
            begin
                sar     <= cmp_sync ? trial : sar; // [RULE_24]
                bit_idx <= bit_idx - 3'h1;
            end
        end
    end

    // Control byte: hardware clears go on completion; a set by the core wins
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            ctl <= CTL_RESET;
        else if (ctl_wr)
            ctl <= {next_sel, ctl_wdata[CTL_CHAN_HI:CTL_CHAN_LO],
                    ctl_wdata[CTL_GO_BIT] && ctl_wdata[CTL_ON_BIT] && on_bit, 1'b0, ctl_wdata[CTL_ON_BIT]}; // [RULE_07]
        else if (finish || sleep_abort)
            ctl[CTL_GO_BIT] <= 1'b0; // [RULE_11]
    end

    // Result: last completed conversion or last core write, whichever later
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            conversion_result <= RESULT_RESET;
        else if (finish && !abort)
            conversion_result <= cmp_sync ? trial : sar; // [RULE_09] [RULE_08]
        else if (result_wr)
            conversion_result <= result_wdata; // [RULE_09]
    end

    // Done flag; a completion in the clearing cycle is kept
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            conv_done_irq_flag <= 1'b0;
        else if (finish)
            conv_done_irq_flag <= 1'b1; // [RULE_11]
        else if (irq_flag_clear)
            conv_done_irq_flag <= 1'b0;
    end

    // Sleep power-down keeps the on-bit set but stops the analog core
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            powered_down <= 1'b0;
            wake_request <= 1'b0;
        end
        else
        begin
            wake_request <= finish && sleep_mode && conv_done_irq_enable; // [RULE_17]
            if (!sleep_mode || !on_bit)
                powered_down <= 1'b0;
            else if ((finish && !conv_done_irq_enable) || sleep_abort)
                powered_down <= 1'b1; // [RULE_18] [RULE_19]
        end
    end

    // Analog drive registered to avoid glitches on the capacitor array
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dac_code          <= 8'h00;
            sample_switch     <= 1'b0;
            converter_powered <= 1'b0;
        end
        else
        begin
            dac_code          <= (state == ACS_CONVERT) ? trial : 8'h00;
            sample_switch     <= active && (state == ACS_IDLE || state == ACS_DELAY || state == ACS_SAMPLE); // [RULE_22]
            converter_powered <= active; // [RULE_23]
        end
    end

    assign ctl_rdata = ctl; // [RULE_18]

endmodule : acs_sequencer

// [inc/acs_pkg.sv]
// Constants shared by the conversion sequencer and its bit-period divider.
// Assumes a single 250 MHz reference clock; the RC source is modelled as a divider.
package acs_pkg;

    // Clock select codes
    localparam logic [1:0] CLK_SEL_DIV2  = 2'h0;
    localparam logic [1:0] CLK_SEL_DIV8  = 2'h1;
    localparam logic [1:0] CLK_SEL_DIV32 = 2'h2;
    localparam logic [1:0] CLK_SEL_RC    = 2'h3;

    // Control byte field positions
    localparam int CTL_CLK_SEL_HI = 7;
    localparam int CTL_CLK_SEL_LO = 6;
    localparam int CTL_CHAN_HI    = 5;
    localparam int CTL_CHAN_LO    = 3;
    localparam int CTL_GO_BIT     = 2;
    localparam int CTL_ON_BIT     = 0;

    // Reset values
    localparam logic [7:0] CTL_RESET    = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;

    // Timing
    localparam int  REF_CLK_MHZ       = 250;
    localparam int  OSC_DIV2          = 2;
    localparam int  OSC_DIV8          = 8;
    localparam int  OSC_DIV32         = 32;
    localparam int  RC_PERIOD_NS      = 4000;
    localparam int  RC_PERIOD_CYC     = (RC_PERIOD_NS * REF_CLK_MHZ) / 1000;
    localparam int  INSTR_CYCLE_OSC   = 4;
    localparam int  SAMPLE_HALF_BITS  = 3;
    localparam int  RESULT_BITS       = 8;
    localparam int  HOLD_OFF_BITS     = 2;

    // Sequencer states
    typedef enum logic [2:0] {
        ACS_IDLE    = 3'b000,
        ACS_DELAY   = 3'b001,
        ACS_SAMPLE  = 3'b010,
        ACS_CONVERT = 3'b011,
        ACS_HOLDOFF = 3'b100
    } acs_state_type;

endpackage : acs_pkg

// [verilog/acs_bit_clock.sv]
// Bit-period divider: emits a pulse every bit period and half bit period.
// Assumes the reference clock is the device oscillator.
`timescale 1ns/10ps
module acs_bit_clock
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    // Control
    input  wire logic       run,
    input  wire logic [1:0] clk_sel,
    // Enables
    output logic            half_tick,
    output logic            bit_tick
);
    import acs_pkg::*;

    logic [15:0] count;
    logic        phase;
    wire  [15:0] half_len;
    wire         wrap;

    // Half of each bit period, so the 9.5-period total is exact
    assign half_len = (clk_sel == CLK_SEL_DIV2)  ? 16'(OSC_DIV2 / 2) :
                      (clk_sel == CLK_SEL_DIV8)  ? 16'(OSC_DIV8 / 2) :
                      (clk_sel == CLK_SEL_DIV32) ? 16'(OSC_DIV32 / 2) :
                                                   16'(RC_PERIOD_CYC / 2); // [RULE_02] [RULE_04]
    assign wrap      = run && (count >= half_len - 16'h0001);
    assign half_tick = wrap;
    assign bit_tick  = wrap && phase;

    // Divider restarts whenever the sequencer stops, aligning periods to start.
    // Phase idles high so the third half tick of sampling is a bit edge and
    // every result bit then gets a full period.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count <= 16'h0000;
            phase <= 1'b1;
        end
        else if (!run)
        begin
            count <= 16'h0000;
            phase <= 1'b1;
        end
        else if (wrap)
        begin
            count <= 16'h0000;
            phase <= ~phase;
        end
        else
            count <= count + 16'h0001;
    end

endmodule : acs_bit_clock

// [tb/acs_analog_model.sv]
// Comparator standing in for the sample-and-hold and trial DAC.
// Assumes the held level stays put for a whole conversion.
`timescale 1ns/10ps
module acs_analog_model
(
    // Trial code and held level
    input  wire logic [7:0] dac_code,
    input  wire logic [7:0] held_level,
    // Decision
    output logic            comparator_in
);
    // High while the trial code does not exceed the held level
    assign comparator_in = (dac_code <= held_level);
endmodule : acs_analog_model

// [tb/acs_sequencer_chk.sv]
// Port assertions for the conversion sequencer.
// Assumes binding into acs_sequencer; go reads back on ctl_rdata bit 2.
`timescale 1ns/10ps
module acs_sequencer_chk
    import acs_pkg::*;
(
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       nrst,
    // Watched ports
    input wire logic [7:0] ctl_rdata,
    input wire logic [7:0] conversion_result,
    input wire logic       result_wr,
    input wire logic       conv_done_irq_enable,
    input wire logic       conv_done_irq_flag,
    input wire logic       sleep_mode,
    input wire logic       wake_request,
    input wire logic       sample_switch,
    input wire logic       converter_powered
);
    logic [9:0] busy_cnt;
    wire        is_div8 = (ctl_rdata[7:6] == CLK_SEL_DIV8);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Busy length, so the finish moment can be bounded
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            busy_cnt <= 10'h000;
        else
            busy_cnt <= ctl_rdata[2] ? busy_cnt + 10'h001 : 10'h000;
    end
    // Two bit periods (16 cycles at div8) off, then acquisition resumes
    sequence cap_holdoff;
        ##1 !sample_switch [*8] ##1 !sample_switch [*8] ##[1:4] sample_switch;
    endsequence
    sequence finished;
        $rose(conv_done_irq_flag) && !sleep_mode && is_div8;
    endsequence
    sequence aborted;
        $fell(ctl_rdata[2]) && !conv_done_irq_flag && !sleep_mode && is_div8;
    endsequence
    conv_done_a: assert property ($rose(conv_done_irq_flag) |-> !ctl_rdata[2] && $past(ctl_rdata[2]))
        else $error("done flag rose without go clearing");
    conv_time_a: assert property (finished |-> busy_cnt inside {[75:79]})
        else $error("div8 conversion length off");
    done_hold_a: assert property (finished |-> cap_holdoff)
        else $error("capacitor hold-off after finish wrong");
    abort_hold_a: assert property (aborted |-> cap_holdoff)
        else $error("hold-off after abort wrong");
    result_hold_a: assert property (!$past(result_wr) && !$rose(conv_done_irq_flag) |-> $stable(conversion_result))
        else $error("result changed without finish or write");
    sleep_abort_a: assert property (sleep_mode && ctl_rdata[2] && ctl_rdata[7:6] != CLK_SEL_RC
        |-> ##[1:4] (!converter_powered && ctl_rdata[0]))
        else $error("sleep with oscillator source did not power down");
    wake_req_a: assert property ($rose(conv_done_irq_flag) && sleep_mode && conv_done_irq_enable |-> ##[0:2] wake_request)
        else $error("no wake after sleep finish");
    wake_pulse_a: assert property (wake_request |-> (!ctl_rdata[2] && conv_done_irq_flag) ##1 !wake_request)
        else $error("wake pulse malformed");
endmodule : acs_sequencer_chk

bind acs_sequencer acs_sequencer_chk chk
(
    .ref_clk, .nrst, .ctl_rdata, .conversion_result, .result_wr, .conv_done_irq_enable,
    .conv_done_irq_flag, .sleep_mode, .wake_request, .sample_switch, .converter_powered
);

// [tb/acs_sequencer_test.sv]
// Random and corner-case bench for the conversion sequencer.
// Assumes the comparator model and the checker bound into the design.
`timescale 1ns/10ps
module acs_sequencer_test;
    import acs_pkg::*;
    logic       ref_clk = 1'b0, nrst = 1'b0, ctl_wr = 1'b0, result_wr = 1'b0, irq_flag_clear = 1'b0;
    logic       conv_done_irq_enable = 1'b0, sleep_mode = 1'b0, woke = 1'b0;
    logic [7:0] ctl_wdata = 8'h00, result_wdata = 8'h00, level = 8'h00, v;
    logic [4:0] port_pins = 5'h00, analog_pin_mask = 5'h00, port_read;
    logic [7:0] ctl_rdata, conversion_result, dac_code;
    logic       conv_done_irq_flag, wake_request, comparator_in, sample_switch, converter_powered;
    logic [1:0] sels [6] = '{CLK_SEL_DIV8, CLK_SEL_DIV8, CLK_SEL_DIV8, CLK_SEL_DIV8, CLK_SEL_DIV2, CLK_SEL_DIV32};
    int         num_errors = 0, n_tests = 0, n;
    // Reference clock, 4 ns
    always #2 ref_clk = ~ref_clk;
    // Wake lasts one cycle, so latch it until the next control write
    always @(posedge ref_clk)
        if (wake_request === 1'b1)
            woke <= 1'b1;
        else if (ctl_wr)
            woke <= 1'b0;
    acs_sequencer dut
    (
        .ref_clk, .nrst, .ctl_wr, .ctl_wdata, .ctl_rdata, .result_wr, .result_wdata, .conversion_result,
        .conv_done_irq_enable, .irq_flag_clear, .conv_done_irq_flag, .sleep_mode, .wake_request,
        .comparator_in, .dac_code, .sample_switch, .converter_powered, .port_pins, .analog_pin_mask, .port_read
    );
    acs_analog_model cmp
    (
        .dac_code, .held_level(level), .comparator_in
    );
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t: got %h, want %h", $time, seen, exp);
        end
    endtask : check
    // Inputs change 1 ns after the edge
    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic wr_ctl(input logic [7:0] b);
        ctl_wdata = b;
        ctl_wr = 1'b1;
        step(1);
        ctl_wr = 1'b0;
        step(1);
    endtask : wr_ctl
    // Select while idle, then go in a later write so it is not dropped
    task automatic start(input logic [1:0] sel);
        irq_flag_clear = 1'b1;
        wr_ctl({sel, 6'b000001});
        irq_flag_clear = 1'b0;
        wr_ctl({sel, 3'($urandom), 3'b101});
    endtask : start
    task automatic wait_idle;
        n = 0;
        while (ctl_rdata[2] === 1'b1 && n < 12000)
        begin
            step(1);
            n++;
        end
    endtask : wait_idle
    // Edges from the one after the go write to finish: 9.5 bit periods, plus the RC start delay
    function automatic logic in_span(input int got, input logic [1:0] sel);
        int t;
        t = (sel == CLK_SEL_DIV2) ? OSC_DIV2 : (sel == CLK_SEL_DIV8) ? OSC_DIV8 : OSC_DIV32;
        t = (sel == CLK_SEL_RC) ? INSTR_CYCLE_OSC + 19 * RC_PERIOD_CYC / 2 : 19 * t / 2;
        return got >= t - 2 && got <= t + 2;
    endfunction : in_span
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // Two RC conversions dominate the run; this allows about twice its length
    initial
    begin
        #(50000 * 4);
        num_errors++;
        give_verdict();
    end
    initial
    begin
        void'($urandom(23));
        step(20);
        nrst = 1'b1;
        step(1);
        check({ctl_rdata, conversion_result}, {CTL_RESET, RESULT_RESET});
        wr_ctl(8'h4d);
        check({ctl_rdata[2], converter_powered}, 2'b01);
        check(ctl_rdata, 8'h49);
        // Random levels only at div8 or slower, the shortest period with a valid result here
        foreach (sels[i])
        begin
            level = (i == 0) ? 8'h00 : (i < 4) ? 8'($urandom) : 8'hff;
            start(sels[i]);
            wait_idle();
            check(conversion_result, level);
            check({ctl_rdata[2], conv_done_irq_flag}, 2'b01);
            check(in_span(n, sels[i]), 1'b1);
            step(2 * OSC_DIV32 + 8);
        end
        // Mixed-rate conversion, top four bits checked: div8 switched to div2 after 2 + 4 bit periods, 50 edges in
        level = 8'($urandom);
        start(CLK_SEL_DIV8);
        step(47);
        wr_ctl({CLK_SEL_DIV2, 6'b000101});
        wait_idle();
        check(16'(n), 16'((2 + 4) * OSC_DIV8 + (8 - 4) * OSC_DIV2 - (1 + 47 + 2)));
        check(conversion_result[7:4], level[7:4]);
        step(16);
        // Refused RC switch while busy, then abort
        v = conversion_result;
        start(CLK_SEL_DIV8);
        step(30);
        wr_ctl({CLK_SEL_RC, 6'b000101});
        check(ctl_rdata[7:6], CLK_SEL_DIV8);
        wr_ctl({CLK_SEL_DIV8, 6'b000001});
        step(40);
        check({conversion_result, conv_done_irq_flag, sample_switch}, {v, 2'b01});
        v = 8'($urandom);
        result_wdata = v;
        result_wr = 1'b1;
        step(1);
        result_wr = 1'b0;
        check(conversion_result, v);
        for (int i = 0; i < 8; i++)
        begin
            port_pins = 5'($urandom);
            analog_pin_mask = (i == 0) ? 5'h1f : 5'($urandom);
            step(3);
            check(port_read, port_pins & ~analog_pin_mask);
        end
        // Sleep with an oscillator source mid-run
        start(CLK_SEL_DIV32);
        step(40);
        sleep_mode = 1'b1;
        step(8);
        check({converter_powered, ctl_rdata[0], conv_done_irq_flag}, 3'b010);
        sleep_mode = 1'b0;
        step(80);
        wr_ctl(8'h00);
        step(2);
        check(converter_powered, 1'b0);
        // RC conversions in sleep, first with the done interrupt, then without
        for (int i = 0; i < 2; i++)
        begin
            conv_done_irq_enable = (i == 0);
            level = 8'($urandom);
            start(CLK_SEL_RC);
            sleep_mode = 1'b1;
            wait_idle();
            step(3);
            check(conversion_result, level);
            check(in_span(n, CLK_SEL_RC), 1'b1);
            check({woke, converter_powered, ctl_rdata[0]}, {{2{conv_done_irq_enable}}, 1'b1});
            sleep_mode = 1'b0;
            step(2 * RC_PERIOD_CYC + 8);
        end
        give_verdict();
    end
endmodule : acs_sequencer_test
